// [inc/xfer_pkg.sv]
/*
 * Shared constants and types for the transfer instruction timing block:
 * opcode patterns, encoded lengths, cycle counts, classes and states.
 * Assumes opcodes arrive one byte at a time, opcode byte first.
 */
package xfer_pkg;

	// --------------------------------------------------------------------
	// Widths
	// --------------------------------------------------------------------
	localparam int LEN_W = 2;
	localparam int CYC_W = 3;

	// --------------------------------------------------------------------
	// Opcode patterns and masks
	// --------------------------------------------------------------------
	localparam logic [7:0] MASK_PTR      = 8'hfe;
	localparam logic [7:0] MASK_WORK     = 8'hf8;
	localparam logic [7:0] OPC_IND_DIR   = 8'ha6;
	localparam logic [7:0] OPC_IND_IMM   = 8'h76;
	localparam logic [7:0] OPC_DP_LOAD   = 8'h90;
	localparam logic [7:0] OPC_CODE_DP   = 8'h93;
	localparam logic [7:0] OPC_CODE_PC   = 8'h83;
	localparam logic [7:0] OPC_EXT_RD_IND = 8'he2;
	localparam logic [7:0] OPC_EXT_RD_DP = 8'he0;
	localparam logic [7:0] OPC_EXT_WR_IND = 8'hf2;
	localparam logic [7:0] OPC_EXT_WR_DP = 8'hf0;
	localparam logic [7:0] OPC_PUSH      = 8'hc0;
	localparam logic [7:0] OPC_POP       = 8'hd0;
	localparam logic [7:0] OPC_SWAP_WORK = 8'hc8;
	localparam logic [7:0] OPC_SWAP_DIR  = 8'hc5;
	localparam logic [7:0] OPC_SWAP_IND  = 8'hc6;
	localparam logic [7:0] OPC_SWAP_NIB  = 8'hd6;

	// --------------------------------------------------------------------
	// Encoded lengths in bytes, opcode included
	// --------------------------------------------------------------------
	localparam logic [LEN_W-1:0] LEN_ONE   = 2'h1;
	localparam logic [LEN_W-1:0] LEN_TWO   = 2'h2;
	localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;

	// --------------------------------------------------------------------
	// Execution times in CPU clock cycles
	// --------------------------------------------------------------------
	localparam logic [CYC_W-1:0] CYC_IND_DIR    = 3'h3;
	localparam logic [CYC_W-1:0] CYC_IND_IMM    = 3'h2;
	localparam logic [CYC_W-1:0] CYC_DP_LOAD    = 3'h3;
	localparam logic [CYC_W-1:0] CYC_CODE_DP    = 3'h5;
	localparam logic [CYC_W-1:0] CYC_CODE_PC    = 3'h4;
	localparam logic [CYC_W-1:0] CYC_EXT_RD_IND = 3'h4;
	localparam logic [CYC_W-1:0] CYC_EXT_RD_DP  = 3'h3;
	localparam logic [CYC_W-1:0] CYC_EXT_WR_IND = 3'h5;
	localparam logic [CYC_W-1:0] CYC_EXT_WR_DP  = 3'h4;
	localparam logic [CYC_W-1:0] CYC_PUSH       = 3'h3;
	localparam logic [CYC_W-1:0] CYC_POP        = 3'h2;
	localparam logic [CYC_W-1:0] CYC_SWAP_WORK  = 3'h2;
	localparam logic [CYC_W-1:0] CYC_SWAP_DIR   = 3'h3;
	localparam logic [CYC_W-1:0] CYC_SWAP_IND   = 3'h3;
	localparam logic [CYC_W-1:0] CYC_SWAP_NIB   = 3'h3;

	// --------------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------------
	localparam logic [LEN_W-1:0] LEN_RST  = 2'h0;
	localparam logic [CYC_W-1:0] CYC_RST  = 3'h0;
	localparam logic [7:0]       BYTE_RST = 8'h00;
	localparam logic [2:0]       SEL_RST  = 3'h0;

	// --------------------------------------------------------------------
	// Types
	// --------------------------------------------------------------------
	typedef enum logic [3:0] {
		CL_NONE, CL_IND_DIR, CL_IND_IMM, CL_DP_LOAD, CL_CODE_DP,
		CL_CODE_PC, CL_EXT_RD_IND, CL_EXT_RD_DP, CL_EXT_WR_IND,
		CL_EXT_WR_DP, CL_PUSH, CL_POP, CL_SWAP_WORK, CL_SWAP_DIR,
		CL_SWAP_IND, CL_SWAP_NIB
	} xfer_class_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} seq_state_t;

endpackage : xfer_pkg

// [src/opcode_lookup.sv]
/*
 * Combinational opcode table: class, length and cycle count of a
 * transfer instruction. Assumes the caller registers the results.
 */
`timescale 1ns/100ps

module opcode_lookup
	import xfer_pkg::*;
(
	// Opcode in
	input  wire logic [7:0]       op,
	// Decode out
	output xfer_class_t           cls,
	output logic [LEN_W-1:0]      len,
	output logic [CYC_W-1:0]      cyc
);

	always_comb begin
		cls = CL_NONE;
		if ((op & MASK_PTR) == OPC_IND_DIR) cls = CL_IND_DIR;
		else if ((op & MASK_PTR) == OPC_IND_IMM) cls = CL_IND_IMM;
		else if (op == OPC_DP_LOAD) cls = CL_DP_LOAD;
		else if (op == OPC_CODE_DP) cls = CL_CODE_DP;
		else if (op == OPC_CODE_PC) cls = CL_CODE_PC;
		else if ((op & MASK_PTR) == OPC_EXT_RD_IND) cls = CL_EXT_RD_IND;
		else if (op == OPC_EXT_RD_DP) cls = CL_EXT_RD_DP;
		else if ((op & MASK_PTR) == OPC_EXT_WR_IND) cls = CL_EXT_WR_IND;
		else if (op == OPC_EXT_WR_DP) cls = CL_EXT_WR_DP;
		else if (op == OPC_PUSH) cls = CL_PUSH;
		else if (op == OPC_POP) cls = CL_POP;
		else if ((op & MASK_WORK) == OPC_SWAP_WORK) cls = CL_SWAP_WORK;
		else if (op == OPC_SWAP_DIR) cls = CL_SWAP_DIR;
		else if ((op & MASK_PTR) == OPC_SWAP_IND) cls = CL_SWAP_IND;
		else if ((op & MASK_PTR) == OPC_SWAP_NIB) cls = CL_SWAP_NIB;
	end

	// RULE16 lengths hold all bytes
	always_comb begin
		case (cls)
			// RULE1 direct to indirect
			CL_IND_DIR: begin
				len = LEN_TWO;
				cyc = CYC_IND_DIR;
			end
			// RULE2 immediate to indirect
			CL_IND_IMM: begin
				len = LEN_TWO;
				cyc = CYC_IND_IMM;
			end
			// RULE3 pointer constant load
			CL_DP_LOAD: begin
				len = LEN_THREE;
				cyc = CYC_DP_LOAD;
			end
			// RULE4 table read via pointer
			CL_CODE_DP: begin
				len = LEN_ONE;
				cyc = CYC_CODE_DP;
			end
			// RULE5 table read via counter
			CL_CODE_PC: begin
				len = LEN_ONE;
				cyc = CYC_CODE_PC;
			end
			// RULE6 short external read
			CL_EXT_RD_IND: begin
				len = LEN_ONE;
				cyc = CYC_EXT_RD_IND;
			end
			// RULE7 long external read
			CL_EXT_RD_DP: begin
				len = LEN_ONE;
				cyc = CYC_EXT_RD_DP;
			end
			// RULE8 short external write
			CL_EXT_WR_IND: begin
				len = LEN_ONE;
				cyc = CYC_EXT_WR_IND;
			end
			// RULE9 long external write
			CL_EXT_WR_DP: begin
				len = LEN_ONE;
				cyc = CYC_EXT_WR_DP;
			end
			// RULE10 stack push
			CL_PUSH: begin
				len = LEN_TWO;
				cyc = CYC_PUSH;
			end
			// RULE11 stack pop
			CL_POP: begin
				len = LEN_TWO;
				cyc = CYC_POP;
			end
			// RULE12 work register swap
			CL_SWAP_WORK: begin
				len = LEN_ONE;
				cyc = CYC_SWAP_WORK;
			end
			// RULE13 direct byte swap
			CL_SWAP_DIR: begin
				len = LEN_TWO;
				cyc = CYC_SWAP_DIR;
			end
			// RULE14 indirect byte swap
			CL_SWAP_IND: begin
				len = LEN_ONE;
				cyc = CYC_SWAP_IND;
			end
			// RULE15 low nibble swap
			CL_SWAP_NIB: begin
				len = LEN_ONE;
				cyc = CYC_SWAP_NIB;
			end
			default: begin
				len = LEN_RST;
				cyc = CYC_RST;
			end
		endcase
	end

endmodule : opcode_lookup

// [src/transfer_timing.sv]
/*
 * Sequencer for data-transfer instructions: takes the opcode byte,
 * collects operand bytes and holds the instruction for its count of CPU
 * cycles, one cycle more for each cycle an operand byte is late, then reports completion.
 * Assumes the byte source sits on CLK_SYS and that memories add no waits.
 */
//
// Behaviour
// RULE1 - Direct byte to indirect RAM is 2 bytes and 3 cycles.
// RULE2 - Immediate to indirect RAM is 2 bytes and 2 cycles.
// RULE3 - Pointer load with a 16-bit constant is 3 bytes and 3 cycles.
// RULE4 - Code read at accumulator plus pointer is 1 byte, 5 cycles.
// RULE5 - Code read at accumulator plus counter is 1 byte, 4 cycles.
// RULE6 - External read with 8-bit indirect address is 1 byte, 4 cycles.
// RULE7 - External read with 16-bit pointer is 1 byte, 3 cycles.
// RULE8 - External write with 8-bit indirect address is 1 byte, 5 cycles.
// RULE9 - External write with 16-bit pointer is 1 byte, 4 cycles.
// RULE10 - Push of a direct byte is 2 bytes and 3 cycles.
// RULE11 - Pop into a direct byte is 2 bytes and 2 cycles.
// RULE12 - Swap of accumulator and work register is 1 byte, 2 cycles.
// RULE13 - Swap of accumulator and direct byte is 2 bytes, 3 cycles.
// RULE14 - Swap of accumulator and indirect RAM is 1 byte, 3 cycles.
// RULE15 - Low nibble swap with indirect RAM is 1 byte and 3 cycles.
// RULE16 - Lengths count opcode and operands; cycles assume no waits.
`timescale 1ns/100ps

module transfer_timing
	import xfer_pkg::*;
(
	// Clock and reset
	input  wire logic             CLK_SYS,
	input  wire logic             RST,
	// Instruction byte stream
	input  wire logic             OP_VALID,
	input  wire logic [7:0]       OP_BYTE,
	output logic                  OP_READY,
	// Sequencing status
	output logic                  BUSY,
	output logic                  INSTR_DONE,
	output logic                  BAD_OPCODE,
	// Decoded instruction
	output xfer_class_t           INSTR_CLASS,
	output logic [LEN_W-1:0]      INSTR_LEN,
	output logic [CYC_W-1:0]      INSTR_CYCLES,
	output logic [2:0]            REG_SEL,
	output logic [7:0]            OPERAND_A,
	output logic [7:0]            OPERAND_B
);

	// --------------------------------------------------------------------
	// Decode
	// --------------------------------------------------------------------
	xfer_class_t      lk_cls;
	logic [LEN_W-1:0] lk_len;
	logic [CYC_W-1:0] lk_cyc;

	opcode_lookup u_lookup (
		.op  (OP_BYTE),
		.cls (lk_cls),
		.len (lk_len),
		.cyc (lk_cyc)
	);

	// --------------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------------
	seq_state_t       state_ff;
	xfer_class_t      cls_ff;
	logic [LEN_W-1:0] len_ff;
	logic [CYC_W-1:0] cyc_ff;
	logic [LEN_W-1:0] left_ff;
	logic [CYC_W-1:0] cnt_ff;
	logic             done_ff;
	logic             bad_ff;
	logic [2:0]       sel_ff;
	logic [7:0]       opa_ff;
	logic [7:0]       opb_ff;
	logic             take_op;
	logic             take_arg;
	logic             advance;
	logic             last_cyc;

	assign take_op  = (state_ff == ST_IDLE) && OP_VALID;
	assign take_arg = (state_ff == ST_EXEC) && (left_ff != LEN_RST)
		&& OP_VALID;
	// A missing operand byte stalls the count, so the figures hold only
	// while the source keeps pace
	assign advance  = (state_ff == ST_EXEC)
		&& ((left_ff == LEN_RST) || OP_VALID);
	assign last_cyc = advance && (cnt_ff == 3'h1);

	assign OP_READY     = (state_ff == ST_IDLE) || (left_ff != LEN_RST);
	assign BUSY         = (state_ff == ST_EXEC);
	assign INSTR_DONE   = done_ff;
	assign BAD_OPCODE   = bad_ff;
	assign INSTR_CLASS  = cls_ff;
	assign INSTR_LEN    = len_ff;
	assign INSTR_CYCLES = cyc_ff;
	assign REG_SEL      = sel_ff;
	assign OPERAND_A    = opa_ff;
	assign OPERAND_B    = opb_ff;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			state_ff <= ST_IDLE;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (take_op && (lk_cls != CL_NONE))
						state_ff <= ST_EXEC;
				end
				ST_EXEC: begin
					if (last_cyc)
						state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// RULE16 opcode cycle counts once
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			cnt_ff <= CYC_RST;
		end else if (take_op) begin
			cnt_ff <= lk_cyc - 3'h1;
		end else if (advance) begin
			cnt_ff <= cnt_ff - 3'h1;
		end
	end

	// RULE16 operands follow opcode
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			left_ff <= LEN_RST;
		end else if (take_op && (lk_cls != CL_NONE)) begin
			left_ff <= lk_len - 2'h1;
		end else if (take_arg) begin
			left_ff <= left_ff - 2'h1;
		end
	end

	// Decoded fields stand until the next opcode is taken
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			cls_ff <= CL_NONE;
			len_ff <= LEN_RST;
			cyc_ff <= CYC_RST;
			sel_ff <= SEL_RST;
		end else if (take_op) begin
			cls_ff <= lk_cls;
			len_ff <= lk_len;
			cyc_ff <= lk_cyc;
			sel_ff <= OP_BYTE[2:0];
		end
	end

	// RULE3 constant high byte first
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			opa_ff <= BYTE_RST;
			opb_ff <= BYTE_RST;
		end else if (take_arg) begin
			if (left_ff == len_ff - 2'h1)
				opa_ff <= OP_BYTE;
			else
				opb_ff <= OP_BYTE;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			done_ff <= 1'b0;
			bad_ff  <= 1'b0;
		end else begin
			done_ff <= last_cyc;
			bad_ff  <= take_op && (lk_cls == CL_NONE);
		end
	end

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	// Active cycles and bytes taken, counted from the opcode edge
	logic [CYC_W-1:0] run_ff;
	logic [LEN_W-1:0] got_ff;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			run_ff <= CYC_RST;
			got_ff <= LEN_RST;
		end else if (take_op) begin
			run_ff <= 3'h1;
			got_ff <= 2'h1;
		end else begin
			if (advance)
				run_ff <= run_ff + 3'h1;
			if (take_arg)
				got_ff <= got_ff + 2'h1;
		end
	end

	ind_dir_time_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE1
		done_ff && cls_ff == CL_IND_DIR |-> run_ff == 3'h3 && len_ff == 2'h2)
		else $error("direct to indirect move mistimed");
	ind_imm_time_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE2
		done_ff && cls_ff == CL_IND_IMM |-> run_ff == 3'h2 && len_ff == 2'h2)
		else $error("immediate to indirect move mistimed");
	ptr_load_time_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE3
		done_ff && cls_ff == CL_DP_LOAD |-> run_ff == 3'h3 && got_ff == 2'h3)
		else $error("pointer load mistimed");
	code_ptr_time_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE4
		take_op && lk_cls == CL_CODE_DP |=> BUSY [*4] ##1 INSTR_DONE)
		else $error("code read via pointer mistimed");
	code_pc_time_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE5
		take_op && lk_cls == CL_CODE_PC |=> BUSY [*3] ##1 INSTR_DONE)
		else $error("code read via counter mistimed");
	ext_rd8_time_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE6
		take_op && lk_cls == CL_EXT_RD_IND |-> ##4 INSTR_DONE && !BUSY)
		else $error("short external read mistimed");
	ext_rd16_time_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE7
		take_op && lk_cls == CL_EXT_RD_DP |-> ##3 INSTR_DONE)
		else $error("long external read mistimed");
	ext_wr8_time_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE8
		take_op && lk_cls == CL_EXT_WR_IND |-> ##5 $rose(INSTR_DONE))
		else $error("short external write mistimed");
	ext_wr16_time_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE9
		take_op && lk_cls == CL_EXT_WR_DP |=> !INSTR_DONE [*3] ##1 INSTR_DONE)
		else $error("long external write mistimed");
	push_time_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE10
		done_ff && cls_ff == CL_PUSH |-> run_ff == 3'h3 && got_ff == 2'h2)
		else $error("push mistimed");
	pop_time_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE11
		done_ff && cls_ff == CL_POP |-> run_ff == 3'h2 && got_ff == 2'h2)
		else $error("pop mistimed");
	swap_work_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE12
		take_op && lk_cls == CL_SWAP_WORK |=> BUSY ##1 INSTR_DONE && OP_READY)
		else $error("work register swap mistimed");
	swap_direct_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE13
		done_ff && cls_ff == CL_SWAP_DIR |-> run_ff == 3'h3 && len_ff == 2'h2)
		else $error("direct swap mistimed");
	swap_indirect_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE14
		take_op && lk_cls == CL_SWAP_IND |-> ##3 INSTR_DONE && INSTR_LEN == 2'h1)
		else $error("indirect swap mistimed");
	swap_nibble_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE15
		done_ff && cls_ff == CL_SWAP_NIB |-> run_ff == 3'h3 && got_ff == 2'h1)
		else $error("nibble swap mistimed");
	byte_count_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE16
		done_ff |-> got_ff == len_ff && run_ff == cyc_ff)
		else $error("bytes or cycles disagree with decode");

endmodule : transfer_timing

// [tb/tb_transfer_timing.sv]
/*
 * Self-checking bench for transfer_timing: every transfer opcode with
 * random operands, operand stalls, refused bytes, bad opcodes, resets.
 * Assumes xfer_pkg and the design files are compiled before it.
 */
`timescale 1ns/100ps

module tb_transfer_timing
	import xfer_pkg::*;
();

	// ------------------------------
	// Signals
	// ------------------------------
	logic             CLK_SYS;
	logic             RST;
	logic             OP_VALID;
	logic [7:0]       OP_BYTE;
	logic             OP_READY;
	logic             BUSY;
	logic             INSTR_DONE;
	logic             BAD_OPCODE;
	xfer_class_t      INSTR_CLASS;
	logic [LEN_W-1:0] INSTR_LEN;
	logic [CYC_W-1:0] INSTR_CYCLES;
	logic [2:0]       REG_SEL;
	logic [7:0]       OPERAND_A;
	logic [7:0]       OPERAND_B;
	logic [31:0]      rnd;
	logic [7:0]       last_a;
	logic [7:0]       last_b;
	int               mismatches;
	int               n_checks;

	transfer_timing u_transfer_timing (
		.CLK_SYS      (CLK_SYS),
		.RST          (RST),
		.OP_VALID     (OP_VALID),
		.OP_BYTE      (OP_BYTE),
		.OP_READY     (OP_READY),
		.BUSY         (BUSY),
		.INSTR_DONE   (INSTR_DONE),
		.BAD_OPCODE   (BAD_OPCODE),
		.INSTR_CLASS  (INSTR_CLASS),
		.INSTR_LEN    (INSTR_LEN),
		.INSTR_CYCLES (INSTR_CYCLES),
		.REG_SEL      (REG_SEL),
		.OPERAND_A    (OPERAND_A),
		.OPERAND_B    (OPERAND_B)
	);

	initial begin
		CLK_SYS = 1'b0;
		forever #50 CLK_SYS = ~CLK_SYS;
	end

	// ------------------------------
	// Helpers
	// ------------------------------
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xorshift

	// Packed as class, length, cycles; zero length marks a bad opcode
	function automatic logic [15:0] exp_of(input logic [7:0] op);
		casez (op)
			8'b1010_011?: return {CL_IND_DIR, 4'h2, 8'h03};
			8'b0111_011?: return {CL_IND_IMM, 4'h2, 8'h02};
			8'b1001_0000: return {CL_DP_LOAD, 4'h3, 8'h03};
			8'b1001_0011: return {CL_CODE_DP, 4'h1, 8'h05};
			8'b1000_0011: return {CL_CODE_PC, 4'h1, 8'h04};
			8'b1110_001?: return {CL_EXT_RD_IND, 4'h1, 8'h04};
			8'b1110_0000: return {CL_EXT_RD_DP, 4'h1, 8'h03};
			8'b1111_001?: return {CL_EXT_WR_IND, 4'h1, 8'h05};
			8'b1111_0000: return {CL_EXT_WR_DP, 4'h1, 8'h04};
			8'b1100_0000: return {CL_PUSH, 4'h2, 8'h03};
			8'b1101_0000: return {CL_POP, 4'h2, 8'h02};
			8'b1100_1???: return {CL_SWAP_WORK, 4'h1, 8'h02};
			8'b1100_0101: return {CL_SWAP_DIR, 4'h2, 8'h03};
			8'b1100_011?: return {CL_SWAP_IND, 4'h1, 8'h03};
			8'b1101_011?: return {CL_SWAP_NIB, 4'h1, 8'h03};
			default: return {CL_NONE, 4'h0, 8'h00};
		endcase
	endfunction : exp_of

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	// Inputs always move 10 ns after the rising edge
	task automatic step();
		@(posedge CLK_SYS);
		#10;
	endtask : step

	task automatic chk_rst();
		chk("rst_busy", 8'h00, 8'(BUSY));
		chk("rst_ready", 8'h01, 8'(OP_READY));
		chk("rst_pulses", 8'h00, 8'({INSTR_DONE, BAD_OPCODE}));
		chk("rst_class", 8'(CL_NONE), 8'(INSTR_CLASS));
		chk("rst_len", 8'h00, 8'({INSTR_LEN, INSTR_CYCLES, REG_SEL}));
		chk("rst_opa", 8'h00, OPERAND_A);
		chk("rst_opb", 8'h00, OPERAND_B);
	endtask : chk_rst

	// Leaves OP_VALID as it was in the done cycle: the caller drives next
	task automatic run_op(input logic [7:0] op, input logic [7:0] a,
		input logic [7:0] b, input logic stall);
		logic [15:0] e;
		int          len;
		int          owed;
		int          due;
		int          k;
		logic        hold;
		e = exp_of(op);
		len = int'(e[11:8]);
		owed = len - 1;
		hold = stall && owed > 0;
		due = int'(e[7:0]) + int'(hold);
		OP_VALID = 1'b1;
		OP_BYTE = op;
		step();
		chk("class", {4'h0, e[15:12]}, 8'(INSTR_CLASS));
		chk("len", {4'h0, e[11:8]}, 8'(INSTR_LEN));
		chk("cycles", e[7:0], 8'(INSTR_CYCLES));
		chk("reg_sel", {5'h00, op[2:0]}, 8'(REG_SEL));
		k = 1;
		while (INSTR_DONE !== 1'b1 && k <= due) begin
			chk("busy", 8'h01, 8'(BUSY));
			chk("ready", 8'(owed > 0), 8'(OP_READY));
			rnd = xorshift(rnd);
			if (hold) begin
				OP_VALID = 1'b0;
				OP_BYTE = rnd[7:0];
				hold = 1'b0;
			end else if (owed > 0) begin
				OP_VALID = 1'b1;
				OP_BYTE = (owed == len - 1) ? a : b;
				owed--;
			end else begin
				// Bytes offered with nothing owed must be ignored
				OP_VALID = rnd[8];
				OP_BYTE = rnd[7:0];
			end
			step();
			k++;
		end
		chk("done_cycle", 8'(due), 8'(k));
		chk("done", 8'h01, 8'(INSTR_DONE));
		if (INSTR_DONE !== 1'b1)
			finish_test();
		chk("done_busy", 8'h00, 8'(BUSY));
		chk("done_ready", 8'h01, 8'(OP_READY));
		if (len >= 2)
			last_a = a;
		if (len == 3)
			last_b = b;
		chk("operand_a", last_a, OPERAND_A);
		chk("operand_b", last_b, OPERAND_B);
	endtask : run_op

	task automatic bad_op(input logic [7:0] op);
		OP_VALID = 1'b1;
		OP_BYTE = op;
		step();
		chk("bad_flag", 8'h01, 8'(BAD_OPCODE));
		chk("bad_busy", 8'h00, 8'(BUSY));
		chk("bad_class", 8'(CL_NONE), 8'(INSTR_CLASS));
		chk("bad_len", 8'h00, 8'({INSTR_LEN, INSTR_CYCLES}));
	endtask : bad_op

	task automatic idle();
		OP_VALID = 1'b0;
		step();
		chk("pulse_end", 8'h00, 8'({INSTR_DONE, BAD_OPCODE}));
		chk("idle_busy", 8'h00, 8'(BUSY));
		chk("idle_ready", 8'h01, 8'(OP_READY));
	endtask : idle

	// ------------------------------
	// Sequence
	// ------------------------------
	initial begin
		logic [7:0]  op;
		logic [15:0] e;
		rnd = 32'had22;
		mismatches = 0;
		n_checks = 0;
		last_a = 8'h00;
		last_b = 8'h00;
		RST = 1'b1;
		OP_VALID = 1'b0;
		OP_BYTE = 8'h00;
		repeat (3) @(posedge CLK_SYS);
		#10;
		chk_rst();
		RST = 1'b0;
		step();
		// Every transfer opcode once, random spacing and stalls
		for (int i = 0; i < 256; i++) begin
			op = 8'(i);
			e = exp_of(op);
			if (e[11:8] != 4'h0) begin
				rnd = xorshift(rnd);
				run_op(op, rnd[7:0], rnd[15:8], rnd[16]);
				if (rnd[17])
					idle();
			end
		end
		idle();
		// Boundary constants back to back
		run_op(8'h90, 8'hff, 8'h00, 1'b0);
		run_op(8'h90, 8'h00, 8'hff, 1'b1);
		idle();
		// Random mix of good and bad opcodes
		for (int i = 0; i < 300; i++) begin
			rnd = xorshift(rnd);
			op = rnd[7:0];
			e = exp_of(op);
			if (e[11:8] != 4'h0)
				run_op(op, rnd[15:8], rnd[23:16], rnd[24]);
			else
				bad_op(op);
			if (rnd[25])
				idle();
		end
		idle();
		// Reset in the middle of a pointer load
		OP_VALID = 1'b1;
		OP_BYTE = 8'h90;
		step();
		OP_BYTE = 8'h5a;
		RST = 1'b1;
		step();
		chk_rst();
		last_a = 8'h00;
		last_b = 8'h00;
		OP_VALID = 1'b0;
		RST = 1'b0;
		step();
		run_op(8'hf0, 8'h00, 8'h00, 1'b0);
		idle();
		finish_test();
	end

endmodule : tb_transfer_timing
